//--- logic/tbrp_pkg.sv
// Package with register map, field layout and port constants for the trace readout block
package tbrp_pkg;
  // Register offsets (drseg byte addresses)
  localparam logic [15:0] TBRP_OFS_WORD_LO = 16'h3F80;
  localparam logic [15:0] TBRP_OFS_WORD_HI = 16'h3F84;
  localparam logic [15:0] TBRP_OFS_RDP     = 16'h3F88;
  localparam logic [15:0] TBRP_OFS_WRP     = 16'h3F90;
  localparam logic [15:0] TBRP_OFS_ITRIG   = 16'h3FD0;
  localparam logic [15:0] TBRP_OFS_DTRIG   = 16'h3FD8;
  // Field positions
  localparam int TBRP_WRAP_BIT    = 31;
  localparam int TBRP_CLASS_EN    = 28;
  localparam int TBRP_NUM_BRK     = 15;
  localparam int TBRP_WORD_LSB    = 3;
  // Reset values
  localparam logic [31:0] TBRP_TRIG_RST = 32'h0000_0000;
  // Last nibble index per 64-bit word and start-tag codes
  localparam logic [3:0] TBRP_LAST_NIB = 4'hF;
  localparam logic [5:0] TBRP_TAG_0  = 6'h3A;
  localparam logic [5:0] TBRP_TAG_16 = 6'h3B;
  localparam logic [5:0] TBRP_TAG_32 = 6'h3C;
  localparam logic [5:0] TBRP_TAG_48 = 6'h3D;
  localparam logic [5:0] TBRP_SR_0   = 6'h00;
  localparam logic [5:0] TBRP_SR_16  = 6'h10;
  localparam logic [5:0] TBRP_SR_32  = 6'h20;
  localparam logic [5:0] TBRP_SR_48  = 6'h30;
  // Register bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } tbrp_req_t;
  // Port state machine
  typedef enum logic [1:0] {
    TBRP_IDLE = 2'b01,
    TBRP_SEND = 2'b10
  } tbrp_state_t;
endpackage

//--- logic/tbrp_trace_port.sv
// Trace buffer readout registers, off-chip nibble port and breakpoint trace triggers
// What this block does
// - window read returns word at read pointer
// - each lower-half window read advances read pointer
// - pointer wraps to zero past last word
// - upper half first; lower read advances pointer
// - read pointer address field, upper bits zero
// - write pointer shows next store address
// - bit 31 flags buffer wrapped once
// - port is 4-bit data plus clock
// - data moves on both clock edges
// - trace clock divided 1:2 or 1:4
// - trace clock is half the data rate
// - word sent as sixteen nibbles, LSB first
// - first nibble nonzero, idle data zero
// - trace clock runs while probe attached
// - probe-absent input high disables port
// - start tag encoded from shift count
// - trigger inserts event or switches tracing
// - two trigger-enable registers, reset zero
// - bit 28 gates the breakpoint class
// - per-break bit: 0 stop, 1 start
// - ratio bit honoured only in off-chip mode
`timescale 1ns/1ps
module tbrp_trace_port
  import tbrp_pkg::*;
#(
  parameter int AW = 10  // Byte address width of trace memory (field n:0)
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  // Register access
  input  wire tbrp_req_t               reg_req,
  output logic [31:0]                  reg_rdata_q,
  // Trace memory write side from the encoder
  input  wire logic                    tw_wr,
  input  wire logic [63:0]             tw_wdata,
  // Control bits from control/status register
  input  wire logic                    offchip_mode_enable,
  input  wire logic                    trace_clock_ratio_select,
  input  wire logic                    special_trace_mode,
  input  wire logic                    sw_trace_enable,
  // Breakpoint triggers
  input  wire logic [TBRP_NUM_BRK-1:0] ibrk_hit,
  input  wire logic [TBRP_NUM_BRK-1:0] dbrk_hit,
  // Port word source
  input  wire logic                    pw_valid,
  input  wire logic [63:0]             pw_data,
  output logic                         pw_ready_q,
  // Pins
  input  wire logic                    probe_absent_input,
  output logic [3:0]                   trace_nibble_out,
  output logic                         trace_port_clock,
  // Trace control outputs
  output logic                         trace_on_q,
  output logic                         trace_event_q
);
  localparam int DEPTH = 2 ** (AW - TBRP_WORD_LSB);
  localparam logic [AW-1:0] STEP = AW'(8);

  // Storage and pointers
  logic [63:0]   mem_q [DEPTH];
  logic [AW-1:0] rdp_q, wrp_q;
  logic          wrap_q;
  logic [31:0]   itrig_q, dtrig_q;
  logic [31:0]   rdata_d;

  // Register decode
  wire logic rd_lo  = reg_req.rd && reg_req.addr == TBRP_OFS_WORD_LO;
  wire logic wr_rdp = reg_req.wr && reg_req.addr == TBRP_OFS_RDP;
  wire logic wr_wrp = reg_req.wr && reg_req.addr == TBRP_OFS_WRP;
  wire logic [AW-TBRP_WORD_LSB-1:0] rd_idx = rdp_q[AW-1:TBRP_WORD_LSB];
  wire logic [AW-TBRP_WORD_LSB-1:0] wr_idx = wrp_q[AW-1:TBRP_WORD_LSB];
  wire logic [63:0] rd_word = mem_q[rd_idx];
  wire logic [AW-1:0] rdp_inc = rdp_q + STEP;
  wire logic [AW-1:0] wrp_inc = wrp_q + STEP;
  wire logic wrp_last = &wrp_q[AW-1:TBRP_WORD_LSB];

  // Read mux; pointer reserved bits and low three bits read as zero, trigger registers read back all 32 written bits
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (reg_req.addr)
      TBRP_OFS_WORD_LO: rdata_d = rd_word[31:0];
      TBRP_OFS_WORD_HI: rdata_d = rd_word[63:32];
      TBRP_OFS_RDP:     rdata_d = 32'(rdp_q);
      TBRP_OFS_WRP:     rdata_d = {wrap_q, 31'(wrp_q)};
      TBRP_OFS_ITRIG:   rdata_d = itrig_q;
      TBRP_OFS_DTRIG:   rdata_d = dtrig_q;
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) reg_rdata_q <= 32'h0000_0000;
    else if (reg_req.rd) reg_rdata_q <= rdata_d;
  end

  // Trace memory; write side has no reset to keep it plain flops
  always_ff @(posedge ref_clk) begin
    if (tw_wr) mem_q[wr_idx] <= tw_wdata;
  end

  // Read pointer: only the lower-half read advances, so a 32-bit pair reads one word
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rdp_q <= '0;
    else if (wr_rdp) rdp_q <= {reg_req.wdata[AW-1:TBRP_WORD_LSB], 3'h0};
    else if (rd_lo) rdp_q <= rdp_inc;
  end

  // Pointer checks; a lost wrap would make software read past the array
  chk_rdp_advance: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    rd_lo && !wr_rdp |=> rdp_q == $past(rdp_q) + STEP)
    else $error("read pointer did not step one word");
  chk_rdp_wrap: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    rd_lo && !wr_rdp && (&rdp_q[AW-1:TBRP_WORD_LSB]) |=> rdp_q == '0)
    else $error("read pointer did not wrap to zero");
  chk_rdp_readback: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    reg_req.rd && reg_req.addr == TBRP_OFS_RDP |=>
      reg_rdata_q[31:AW] == '0 && reg_rdata_q[TBRP_WORD_LSB-1:0] == '0)
    else $error("read pointer reserved bits not zero");
  cov_rdp_wrap: cover property (@(posedge ref_clk) disable iff (!rstn)
    rd_lo && (&rdp_q[AW-1:TBRP_WORD_LSB]));

  // Write pointer and wrap flag; hardware set wins over a software clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrp_q  <= '0;
      wrap_q <= 1'b0;
    end else if (tw_wr) begin
      wrp_q  <= wrp_inc;
      wrap_q <= wrap_q | wrp_last | (wr_wrp & reg_req.wdata[TBRP_WRAP_BIT]);
    end else if (wr_wrp) begin
      wrp_q  <= {reg_req.wdata[AW-1:TBRP_WORD_LSB], 3'h0};
      wrap_q <= reg_req.wdata[TBRP_WRAP_BIT];
    end
  end

  // Wrap flag must rise with the last slot, else the oldest word is lost to software
  chk_wrap_sets: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    tw_wr && wrp_last |=> wrap_q)
    else $error("wrap flag not set after last slot");
  cov_wrap_flag: cover property (@(posedge ref_clk) disable iff (!rstn)
    tw_wr && wrp_last);

  // Trigger-enable registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      itrig_q <= TBRP_TRIG_RST;
      dtrig_q <= TBRP_TRIG_RST;
    end else begin
      if (reg_req.wr && reg_req.addr == TBRP_OFS_ITRIG) itrig_q <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == TBRP_OFS_DTRIG) dtrig_q <= reg_req.wdata;
    end
  end

  // Breakpoint trace control; start wins if start and stop hit together
  wire logic [TBRP_NUM_BRK-1:0] ihit = ibrk_hit & {TBRP_NUM_BRK{itrig_q[TBRP_CLASS_EN]}};
  wire logic [TBRP_NUM_BRK-1:0] dhit = dbrk_hit & {TBRP_NUM_BRK{dtrig_q[TBRP_CLASS_EN]}};
  wire logic any_hit  = |{ihit, dhit};
  wire logic hit_start = |{ihit & itrig_q[TBRP_NUM_BRK-1:0], dhit & dtrig_q[TBRP_NUM_BRK-1:0]};
  wire logic hit_stop  = |{ihit & ~itrig_q[TBRP_NUM_BRK-1:0], dhit & ~dtrig_q[TBRP_NUM_BRK-1:0]};

  // Software level loads trace state only on a change; triggers own it after that
  logic sw_en_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trace_on_q    <= 1'b0;
      trace_event_q <= 1'b0;
      sw_en_q       <= 1'b0;
    end else begin
      sw_en_q       <= sw_trace_enable;
      trace_event_q <= special_trace_mode & any_hit;
      if (!special_trace_mode && hit_start) trace_on_q <= 1'b1;
      else if (!special_trace_mode && hit_stop) trace_on_q <= 1'b0;
      else if (sw_trace_enable != sw_en_q) trace_on_q <= sw_trace_enable;
    end
  end

  // Trigger checks in normal and special trace mode
  chk_trace_start: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !special_trace_mode && hit_start |=> trace_on_q)
    else $error("start trigger did not switch trace on");
  chk_trace_stop: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !special_trace_mode && hit_stop && !hit_start |=> !trace_on_q)
    else $error("stop trigger did not switch trace off");
  chk_event_pulse: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    special_trace_mode && any_hit |=> trace_event_q)
    else $error("trigger in special mode gave no event");

  // Probe-absent pin synchroniser; first stage feeds only the second
  logic [2:0] prb_q;
  logic       prb_absent_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prb_q        <= 3'b111;
      prb_absent_q <= 1'b1;
    end else begin
      prb_q <= {prb_q[1:0], probe_absent_input};
      if (prb_q[2] == prb_q[1]) prb_absent_q <= prb_q[2];
    end
  end
  wire logic port_en = offchip_mode_enable & ~prb_absent_q;

  // Nibble pacing: full speed sends one nibble per core clock, half speed every second
  logic        pace_q;
  logic        tclk_q;
  wire  logic  full_rate = trace_clock_ratio_select;
  wire  logic  beat = full_rate | pace_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pace_q <= 1'b0;
      tclk_q <= 1'b0;
    end else if (port_en) begin
      pace_q <= ~pace_q;
      if (beat) tclk_q <= ~tclk_q;
    end else begin
      pace_q <= 1'b0;
      tclk_q <= 1'b0;
    end
  end
  assign trace_port_clock = tclk_q;

  // Trace clock moves on every beat and, while the port is on, only then; turning the port off forces it low
  chk_clk_toggle: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    port_en && beat |=> trace_port_clock != $past(trace_port_clock))
    else $error("trace clock missed a beat");
  chk_clk_hold: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    port_en && !beat |=> $stable(trace_port_clock))
    else $error("trace clock moved between beats");

  // Serialiser
  tbrp_state_t st_q;
  logic [63:0] sh_q;
  logic [3:0]  cnt_q;
  logic [3:0]  nib_q;
  wire  logic  take = port_en && beat && st_q == TBRP_IDLE && pw_valid;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q       <= TBRP_IDLE;
      sh_q       <= '0;
      cnt_q      <= '0;
      nib_q      <= 4'h0;
      pw_ready_q <= 1'b0;
    end else begin
      pw_ready_q <= 1'b0;
      case (st_q)
        TBRP_IDLE: begin
          // Cleared on a beat or with the port off, so a half-speed last nibble stands two cycles
          if (!port_en || beat) nib_q <= 4'h0;
          if (take) begin
            pw_ready_q <= 1'b1;
            nib_q      <= pw_data[3:0];
            sh_q       <= pw_data >> 4;
            cnt_q      <= 4'h1;
            st_q       <= TBRP_SEND;
          end
        end
        TBRP_SEND: begin
          if (!port_en) begin
            st_q  <= TBRP_IDLE;
            nib_q <= 4'h0;
          end else if (beat) begin
            nib_q <= sh_q[3:0];
            sh_q  <= sh_q >> 4;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == TBRP_LAST_NIB) st_q <= TBRP_IDLE;
          end
        end
        default: st_q <= TBRP_IDLE;
      endcase
    end
  end
  assign trace_nibble_out = nib_q;

  // Serialiser checks; the probe keys on the first nibble, so it must be the LSBs
  chk_first_nibble: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    take |=> pw_ready_q && trace_nibble_out == $past(pw_data[3:0]))
    else $error("first nibble is not the low nibble");
  chk_idle_zero: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    st_q == TBRP_IDLE && !take && (beat || !port_en) |=> trace_nibble_out == 4'h0)
    else $error("idle nibble not zero");
  cov_full_word: cover property (@(posedge ref_clk) disable iff (!rstn)
    take && full_rate);
  cov_half_word: cover property (@(posedge ref_clk) disable iff (!rstn)
    take && !full_rate);

endmodule

// Start tag encoder for the shift count of a trace word
module tbrp_tag_enc
  import tbrp_pkg::*;
(
  // Shift count in
  input  wire logic [5:0] sr_count,
  // Encoded tag out
  output logic [5:0]      start_tag_code
);
  assign start_tag_code = (sr_count == TBRP_SR_0)  ? TBRP_TAG_0  :
                          (sr_count == TBRP_SR_16) ? TBRP_TAG_16 :
                          (sr_count == TBRP_SR_32) ? TBRP_TAG_32 :
                          (sr_count == TBRP_SR_48) ? TBRP_TAG_48 : sr_count;
endmodule

//--- verif/tbrp_probe_model.sv
// Probe model that collects trace words from the nibble port
`timescale 1ns/1ps
module tbrp_probe_model (
  // Port pins
  input  wire logic       trace_port_clock,
  input  wire logic [3:0] trace_nibble_out,
  // Captured results
  output logic [63:0]     word_q,
  output int              words,
  output int              edges
);
  int cnt;
  initial begin
    word_q = '0;
    words  = 0;
    edges  = 0;
    cnt    = 0;
  end
  // Both edges carry data; wait so data and clock have both landed
  always @(trace_port_clock) begin
    #2;
    edges++;
    if (cnt == 0 && trace_nibble_out != 4'h0) cnt = 1;
    if (cnt != 0) begin
      word_q[(cnt-1)*4 +: 4] = trace_nibble_out;
      if (cnt == 16) begin
        cnt = 0;
        words++;
      end else cnt++;
    end
  end
endmodule

//--- verif/tbrp_trace_port_bench.sv
// Self-checking bench for the trace readout registers, nibble port and triggers
`timescale 1ns/1ps
module tbrp_trace_port_bench;
  import tbrp_pkg::*;
  logic ref_clk = 0, rstn = 0, tw_wr = 0, pw_valid = 0, probe_absent_input = 0;
  logic offchip_mode_enable = 0, trace_clock_ratio_select = 0;
  logic special_trace_mode = 0, sw_trace_enable = 0;
  logic pw_ready_q, trace_port_clock, trace_on_q, trace_event_q;
  logic [63:0] tw_wdata = '0, pw_data = '0, probe_word;
  logic [31:0] reg_rdata_q, rv;
  logic [14:0] ibrk_hit = '0, dbrk_hit = '0;
  logic [3:0]  trace_nibble_out;
  logic [5:0]  sr_count = '0, start_tag_code;
  tbrp_req_t   reg_req = '0;
  int probe_words, probe_edges, mismatches = 0, check_count = 0;

  tbrp_trace_port #(.AW(10)) tbrp_trace_port_i (.ref_clk, .rstn, .reg_req, .reg_rdata_q,
    .tw_wr, .tw_wdata, .offchip_mode_enable, .trace_clock_ratio_select, .special_trace_mode,
    .sw_trace_enable, .ibrk_hit, .dbrk_hit, .pw_valid, .pw_data, .pw_ready_q,
    .probe_absent_input, .trace_nibble_out, .trace_port_clock, .trace_on_q, .trace_event_q);
  tbrp_tag_enc tbrp_tag_enc_i (.sr_count, .start_tag_code);
  tbrp_probe_model tbrp_probe_model_i (.trace_port_clock, .trace_nibble_out,
    .word_q(probe_word), .words(probe_words), .edges(probe_edges));

  always #25 ref_clk = ~ref_clk;

  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  // One register access; an idle cycle follows so requests never abut
  task automatic reg_op(logic r, logic [15:0] a, logic [31:0] d);
    reg_req = '{r, ~r, a, d};
    tick;
    reg_req = '0;
    rv = reg_rdata_q;
    tick;
  endtask
  function automatic logic [63:0] pat(int i);
    return {16'hC0DE, i[15:0], 16'h5A5A, i[15:0]};
  endfunction

  task test_memory;
    reg_op(0, TBRP_OFS_WRP, 32'h0);
    tw_wr = 1;
    for (int i = 0; i < 130; i++) begin
      tw_wdata = pat(i);
      tick;
      if (i == 4) begin
        tw_wr = 0;
        reg_op(1, TBRP_OFS_WRP, 0);
        check("wrp", 32'h0000_0028, rv);
        tw_wr = 1;
      end
    end
    tw_wr = 0;
    reg_op(1, TBRP_OFS_WRP, 0);
    check("wrp wrapped", 32'h8000_0010, rv);
    reg_op(0, TBRP_OFS_RDP, 32'hFFFF_FFFF);
    reg_op(1, TBRP_OFS_RDP, 0);
    check("rdp mask", 32'h0000_03F8, rv);
    reg_op(1, TBRP_OFS_WORD_HI, 0);
    check("hi", pat(127) >> 32, rv);
    reg_op(1, TBRP_OFS_RDP, 0);
    check("rdp after hi", 32'h0000_03F8, rv);
    reg_op(1, TBRP_OFS_WORD_LO, 0);
    check("lo", pat(127) & 64'hFFFF_FFFF, rv);
    reg_op(1, TBRP_OFS_RDP, 0);
    check("rdp wrap", 32'h0, rv);
    reg_op(1, TBRP_OFS_WORD_HI, 0);
    check("hi0", pat(128) >> 32, rv);
    reg_op(1, TBRP_OFS_WORD_LO, 0);
    check("lo0", pat(128) & 64'hFFFF_FFFF, rv);
    reg_op(1, TBRP_OFS_RDP, 0);
    check("rdp step", 32'h0000_0008, rv);
    reg_op(1, TBRP_OFS_WRP, 0);
    reg_op(0, TBRP_OFS_RDP, rv[TBRP_WRAP_BIT] ? {1'b0, rv[30:0]} : 32'h0);
    reg_op(1, TBRP_OFS_WORD_HI, 0);
    check("oldest hi", pat(2) >> 32, rv);
    reg_op(1, TBRP_OFS_WORD_LO, 0);
    check("oldest lo", pat(2) & 64'hFFFF_FFFF, rv);
    reg_op(1, 16'h3F98, 0);
    check("unmapped", 32'h0, rv);
    $display("test memory done");
  endtask

  task automatic test_port(logic r, logic [63:0] w);
    int n, k, e;
    trace_clock_ratio_select = r;
    offchip_mode_enable = 1;
    repeat (4) tick;
    pw_data = w;
    pw_valid = 1;
    n = 0;
    while (pw_ready_q !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
    check("word taken", 1, pw_ready_q);
    pw_valid = 0;
    k = probe_words;
    n = 0;
    while (probe_words == k && n < 100) begin
      tick;
      n++;
    end
    check("word count", k + 1, probe_words);
    check("probe word", w, probe_word);
    repeat (3) tick;
    e = probe_edges;
    repeat (8) begin
      tick;
      check("idle nibble", 4'h0, trace_nibble_out);
    end
    check("clock edges", r ? 8 : 4, probe_edges - e);
    $display("test port done");
  endtask

  task test_absent;
    logic seen;
    seen = 0;
    probe_absent_input = 1;
    repeat (4) tick;
    pw_valid = 1;
    repeat (30) begin
      tick;
      if (pw_ready_q === 1'b1) seen = 1;
    end
    pw_valid = 0;
    check("taken while absent", 0, seen);
    probe_absent_input = 0;
    $display("test absent done");
  endtask

  task automatic hit(logic d, int b, logic exp_on);
    if (d) dbrk_hit[b] = 1;
    else ibrk_hit[b] = 1;
    tick;
    ibrk_hit = '0;
    dbrk_hit = '0;
    if (!special_trace_mode) check("trace on", exp_on, trace_on_q);
    check("trace event", special_trace_mode, trace_event_q);
    tick;
    if (!special_trace_mode) check("trace on held", exp_on, trace_on_q);
    check("event pulse end", 0, trace_event_q);
  endtask

  task test_trigger;
    logic [5:0] cnt [5] = '{6'h00, 6'h10, 6'h20, 6'h30, 6'h05};
    logic [5:0] tag [5] = '{6'h3A, 6'h3B, 6'h3C, 6'h3D, 6'h05};
    reg_op(1, TBRP_OFS_ITRIG, 0);
    check("itrig reset", 32'h0, rv);
    reg_op(1, TBRP_OFS_DTRIG, 0);
    check("dtrig reset", 32'h0, rv);
    sw_trace_enable = 1;
    tick;
    check("sw trace on", 1, trace_on_q);
    sw_trace_enable = 0;
    tick;
    check("sw trace off", 0, trace_on_q);
    reg_op(0, TBRP_OFS_ITRIG, 32'h1000_0001);
    hit(0, 0, 1);
    hit(0, 1, 0);
    reg_op(0, TBRP_OFS_ITRIG, 32'h0000_0001);
    hit(0, 0, 0);
    reg_op(0, TBRP_OFS_DTRIG, 32'h1000_4000);
    reg_op(1, TBRP_OFS_DTRIG, 0);
    check("dtrig", 32'h1000_4000, rv);
    hit(1, 14, 1);
    special_trace_mode = 1;
    hit(1, 14, 1);
    special_trace_mode = 0;
    for (int i = 0; i < 5; i++) begin
      sr_count = cnt[i];
      tick;
      check("start tag", tag[i], start_tag_code);
    end
    $display("test trigger done");
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well past the few hundred cycles the tests need
  initial begin
    #1000000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rstn = 1;
    tick;
    test_memory;
    test_port(1, 64'hFEDC_BA98_7654_3211);
    test_port(0, 64'h0123_4567_89AB_CDEF);
    test_absent;
    test_trigger;
    finish_test;
  end
endmodule
